// ### gpm_pkg.sv
/*
 * Constants, register map, field layout and mode codes for the four-pin
 * general-purpose port with message-interrupt triggers.
 * Assumes a 250 MHz core clock and a simple strobe register port whose
 * byte addresses are 12 bits wide.
 */
// How it works
// - Two-bit mode field per pin, four modes.
// - Interrupt mode: falling edge fires vector n.
// - Read-only register returns sampled pin levels.
// - Output-value bits drive configured output pins.
// - Output-value reads return stored bits, not pins.
// - Routing bit 0 selects legacy or message.
// - Legacy pins A..D map to vectors 4..7.
// - Mode, output and routing registers reset zero.
package gpm_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PIN_N = 4;
   localparam int MODE_W = 2;
   localparam int LEG_N = 4;
   localparam int VEC_N = PIN_N + LEG_N;
   localparam int LEG_VEC_BASE = 4;
   localparam int CLK_PERIOD_NS = 4;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFF_PIN_MODE_CONTROL = 12'h214;
   localparam logic [ADDR_W-1:0] OFF_PIN_LEVEL_READBACK = 12'h218;
   localparam logic [ADDR_W-1:0] OFF_PIN_OUTPUT_VALUE = 12'h21c;
   localparam logic [ADDR_W-1:0] OFF_LEGACY_IRQ_ROUTING = 12'h220;
   localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 12'h224;
   localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 12'h228;

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam int MODE_FIELD_W = PIN_N * MODE_W;
   localparam int ROUTE_SEL_BIT = 0;
   localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;

   // ************************************************************
   // Pin modes
   // ************************************************************
   typedef enum logic [MODE_W-1:0] {
      GPM_MODE_INPUT = 2'b00,
      GPM_MODE_OUTPUT = 2'b01,
      GPM_MODE_OPEN_DRAIN = 2'b10,
      GPM_MODE_IRQ_IN = 2'b11
   } gpm_mode_t;

endpackage : gpm_pkg

// ### gpm_sync.sv
/*
 * Two-flop level synchroniser, one bit per lane.
 * Assumes inputs are asynchronous to ref_clk; only the second stage is
 * visible outside.
 */
`timescale 1ns/1ns
module gpm_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0 // Per-lane reset level, set to each line's idle level
) (
   input wire logic ref_clk,             // Core clock
   input wire logic nrst,                // Async reset, active low
   input wire logic [WIDTH-1:0] async_in, // Raw pin levels
   output logic [WIDTH-1:0] sync_out      // Synchronised levels
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds the second stage and nothing else
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : gpm_sync

// ### gpm_fall_detect.sv
/*
 * Per-lane falling-edge detector with enable, giving one registered
 * pulse for each high-to-low step of an already synchronised level.
 * Assumes the input is on ref_clk.
 */
`timescale 1ns/1ns
module gpm_fall_detect #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,           // Core clock
   input wire logic nrst,              // Async reset, active low
   input wire logic [WIDTH-1:0] level, // Synchronised level
   input wire logic [WIDTH-1:0] enable, // Lane armed for edges
   output logic [WIDTH-1:0] fall_pulse  // One-cycle pulse per fall
);

   logic [WIDTH-1:0] prev;

   // Previous level starts low so a pin already low at reset fires nothing
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prev <= '0;
      end else begin
         prev <= level;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fall_pulse <= '0;
      end else begin
         fall_pulse <= enable & prev & ~level;
      end
   end

endmodule : gpm_fall_detect

// ### gpm_port.sv
/*
 * Top of the general-purpose port: register file, pin drive, legacy
 * interrupt rerouting, message-vector triggers and a summary interrupt.
 * Assumes a strobe register port on ref_clk, board pins asynchronous to
 * ref_clk, and a message generator that accepts one-cycle trigger pulses.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module gpm_port (
   input wire logic ref_clk,                              // Core clock, 250 MHz
   input wire logic nrst,                                 // Async reset, active low
   input wire logic [gpm_pkg::ADDR_W-1:0] reg_addr,       // Register byte address
   input wire logic [gpm_pkg::DATA_W-1:0] reg_wdata,      // Write data
   input wire logic reg_wr,                               // Write strobe
   input wire logic reg_rd,                               // Read strobe
   output logic [gpm_pkg::DATA_W-1:0] reg_rdata,          // Read data, cycle after strobe
   input wire logic [gpm_pkg::PIN_N-1:0] gpio_in,         // Pin level in
   output logic [gpm_pkg::PIN_N-1:0] gpio_out,            // Pin level out
   output logic [gpm_pkg::PIN_N-1:0] gpio_oe,             // Pin drive enable
   input wire logic [gpm_pkg::LEG_N-1:0] legacy_irq_n_in, // Legacy INTA..D in, low active
   output logic [gpm_pkg::LEG_N-1:0] legacy_irq_n_out,    // Legacy INTA..D onward, low active
   output logic [gpm_pkg::VEC_N-1:0] msg_trigger,         // Message vector pulses
   output logic irq                                       // Summary interrupt, high active
);

   // ************************************************************
   // Functions
   // ************************************************************

   // Mode field of one pin
   function automatic gpm_pkg::gpm_mode_t pin_mode(
      input logic [gpm_pkg::MODE_FIELD_W-1:0] ctrl,
      input int unsigned n
   );
      logic [gpm_pkg::MODE_W-1:0] f;
      f = ctrl[n*gpm_pkg::MODE_W +: gpm_pkg::MODE_W];
      return gpm_pkg::gpm_mode_t'(f);
   endfunction : pin_mode

   // Register hit decode
   function automatic logic hit(
      input logic [gpm_pkg::ADDR_W-1:0] addr,
      input logic [gpm_pkg::ADDR_W-1:0] off
   );
      return addr == off;
   endfunction : hit

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [gpm_pkg::MODE_FIELD_W-1:0] pin_mode_control;
   logic [gpm_pkg::PIN_N-1:0] pin_output_value;
   logic legacy_irq_to_message_select;
   logic [gpm_pkg::VEC_N-1:0] event_status;
   logic [gpm_pkg::VEC_N-1:0] event_mask;
   logic [gpm_pkg::VEC_N-1:0] raw_level;
   logic [gpm_pkg::VEC_N-1:0] sync_level;
   logic [gpm_pkg::VEC_N-1:0] edge_enable;
   logic [gpm_pkg::VEC_N-1:0] fall_pulse;
   logic [gpm_pkg::PIN_N-1:0] pin_level;
   logic [gpm_pkg::LEG_N-1:0] legacy_level_n;
   logic [gpm_pkg::PIN_N-1:0] next_gpio_out;
   logic [gpm_pkg::PIN_N-1:0] next_gpio_oe;
   logic [gpm_pkg::DATA_W-1:0] next_rdata;
   logic wr_mode;
   logic wr_value;
   logic wr_route;
   logic wr_status;
   logic wr_mask;

   // ************************************************************
   // Write decode
   // ************************************************************
   assign wr_mode = reg_wr && hit(reg_addr, gpm_pkg::OFF_PIN_MODE_CONTROL);
   assign wr_value = reg_wr && hit(reg_addr, gpm_pkg::OFF_PIN_OUTPUT_VALUE);
   assign wr_route = reg_wr && hit(reg_addr, gpm_pkg::OFF_LEGACY_IRQ_ROUTING);
   assign wr_status = reg_wr && hit(reg_addr, gpm_pkg::OFF_EVENT_STATUS);
   assign wr_mask = reg_wr && hit(reg_addr, gpm_pkg::OFF_EVENT_MASK);

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_mode_control <= gpm_pkg::REG_RESET[gpm_pkg::MODE_FIELD_W-1:0];
      end else if (wr_mode) begin
         pin_mode_control <= reg_wdata[gpm_pkg::MODE_FIELD_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_output_value <= gpm_pkg::REG_RESET[gpm_pkg::PIN_N-1:0];
      end else if (wr_value) begin
         pin_output_value <= reg_wdata[gpm_pkg::PIN_N-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         legacy_irq_to_message_select <= gpm_pkg::REG_RESET[gpm_pkg::ROUTE_SEL_BIT];
      end else if (wr_route) begin
         legacy_irq_to_message_select <= reg_wdata[gpm_pkg::ROUTE_SEL_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         event_mask <= gpm_pkg::REG_RESET[gpm_pkg::VEC_N-1:0];
      end else if (wr_mask) begin
         event_mask <= reg_wdata[gpm_pkg::VEC_N-1:0];
      end
   end

   // ************************************************************
   // Input synchronisation and edge detection
   // ************************************************************

   // Lanes 0..3 are the port pins, lanes 4..7 the legacy interrupt pins
   assign raw_level = {legacy_irq_n_in, gpio_in};

   // Legacy lines idle high, so their stages reset high; a low reset would pass a false assertion onward
   gpm_sync #(
      .WIDTH(gpm_pkg::VEC_N),
      .RESET_VAL({{gpm_pkg::LEG_N{1'b1}}, {gpm_pkg::PIN_N{1'b0}}})
   ) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(raw_level),
      .sync_out(sync_level)
   );

   assign pin_level = sync_level[gpm_pkg::PIN_N-1:0];
   assign legacy_level_n = sync_level[gpm_pkg::VEC_N-1:gpm_pkg::LEG_VEC_BASE];

   generate
      for (genvar n = 0; n < gpm_pkg::PIN_N; n++) begin : g_pin_arm
         assign edge_enable[n] = pin_mode(pin_mode_control, n) == gpm_pkg::GPM_MODE_IRQ_IN;
      end
      for (genvar k = 0; k < gpm_pkg::LEG_N; k++) begin : g_leg_arm
         // Assertion of INTA..D is a falling edge of the low-active pin
         assign edge_enable[gpm_pkg::LEG_VEC_BASE+k] = legacy_irq_to_message_select;
      end
   endgenerate

   gpm_fall_detect #(
      .WIDTH(gpm_pkg::VEC_N)
   ) u_fall (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .level(sync_level),
      .enable(edge_enable),
      .fall_pulse(fall_pulse)
   );

   // Lane index equals vector number, so the pulse vector is the trigger vector
   assign msg_trigger = fall_pulse;

   // ************************************************************
   // Legacy interrupt pass-through
   // ************************************************************

   // Held deasserted while rerouted so the level path never doubles a message
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         legacy_irq_n_out <= '1;
      end else if (legacy_irq_to_message_select) begin
         legacy_irq_n_out <= '1;
      end else begin
         legacy_irq_n_out <= legacy_level_n;
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   generate
      for (genvar n = 0; n < gpm_pkg::PIN_N; n++) begin : g_drive
         always_comb begin
            unique case (pin_mode(pin_mode_control, n))
               gpm_pkg::GPM_MODE_OUTPUT: begin
                  next_gpio_out[n] = pin_output_value[n];
                  next_gpio_oe[n] = 1'b1;
               end
               gpm_pkg::GPM_MODE_OPEN_DRAIN: begin
                  next_gpio_out[n] = 1'b0;
                  next_gpio_oe[n] = ~pin_output_value[n];
               end
               gpm_pkg::GPM_MODE_INPUT,
               gpm_pkg::GPM_MODE_IRQ_IN: begin
                  next_gpio_out[n] = 1'b0;
                  next_gpio_oe[n] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   // Registered drive costs one cycle but keeps the pads glitch-free
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gpio_out <= '0;
         gpio_oe <= '0;
      end else begin
         gpio_out <= next_gpio_out;
         gpio_oe <= next_gpio_oe;
      end
   end

   // ************************************************************
   // Event status and summary interrupt
   // ************************************************************

   // A new event in the clearing cycle stays set
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         event_status <= gpm_pkg::REG_RESET[gpm_pkg::VEC_N-1:0];
      end else if (wr_status) begin
         event_status <= (event_status & ~reg_wdata[gpm_pkg::VEC_N-1:0]) | fall_pulse;
      end else begin
         event_status <= event_status | fall_pulse;
      end
   end

   assign irq = |(event_status & event_mask);

   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      next_rdata = gpm_pkg::READ_UNMAPPED;
      if (hit(reg_addr, gpm_pkg::OFF_PIN_MODE_CONTROL)) begin
         next_rdata[gpm_pkg::MODE_FIELD_W-1:0] = pin_mode_control;
      end else if (hit(reg_addr, gpm_pkg::OFF_PIN_LEVEL_READBACK)) begin
         next_rdata[gpm_pkg::PIN_N-1:0] = pin_level;
      end else if (hit(reg_addr, gpm_pkg::OFF_PIN_OUTPUT_VALUE)) begin
         next_rdata[gpm_pkg::PIN_N-1:0] = pin_output_value;
      end else if (hit(reg_addr, gpm_pkg::OFF_LEGACY_IRQ_ROUTING)) begin
         next_rdata[gpm_pkg::ROUTE_SEL_BIT] = legacy_irq_to_message_select;
      end else if (hit(reg_addr, gpm_pkg::OFF_EVENT_STATUS)) begin
         next_rdata[gpm_pkg::VEC_N-1:0] = event_status;
      end else if (hit(reg_addr, gpm_pkg::OFF_EVENT_MASK)) begin
         next_rdata[gpm_pkg::VEC_N-1:0] = event_mask;
      end
   end

   // Data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : gpm_port

// ### gpm_port_assertions.sv
/* Checker for gpm_port: read slot, trigger pulses, legacy routing and pin drive.
   Assumes it is bound to gpm_port and sees only the ports of that module. */
`timescale 1ns/1ns
module gpm_port_checker (
   input wire logic ref_clk, // Core clock
   input wire logic nrst, // Async reset, active low
   input wire logic [gpm_pkg::ADDR_W-1:0] reg_addr, // Address
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [gpm_pkg::DATA_W-1:0] reg_rdata, // Read data
   input wire logic [gpm_pkg::PIN_N-1:0] gpio_in, // Pin level in
   input wire logic [gpm_pkg::PIN_N-1:0] gpio_out, // Pin level out
   input wire logic [gpm_pkg::PIN_N-1:0] gpio_oe, // Drive enable
   input wire logic [gpm_pkg::LEG_N-1:0] legacy_irq_n_in, // Legacy lines in
   input wire logic [gpm_pkg::LEG_N-1:0] legacy_irq_n_out, // Legacy lines onward
   input wire logic [gpm_pkg::VEC_N-1:0] msg_trigger, // Vector pulses
   input wire logic irq // Summary interrupt
);
   // Synchronisers still hold reset values on the first edges, so age gates the follow check
   logic [1:0] age;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read slot");
   level_upper_a: assert property (reg_rd && reg_addr == gpm_pkg::OFF_PIN_LEVEL_READBACK |=> reg_rdata[31:4] == 28'h0)
      else $error("pin level upper bits not zero");
   trig_pulse_a: assert property (msg_trigger != 8'h0 |=> (msg_trigger & $past(msg_trigger)) == 8'h0)
      else $error("trigger longer than one cycle");
   pin_fall_a: assert property ((msg_trigger[3:0] & $past(gpio_in, 2)) == 4'h0)
      else $error("pin trigger without low pin");
   leg_fall_a: assert property ((msg_trigger[7:4] & $past(legacy_irq_n_in, 2)) == 4'h0)
      else $error("legacy trigger without asserted line");
   leg_quiet_a: assert property (msg_trigger[7:4] != 4'h0 |-> legacy_irq_n_out == 4'hf)
      else $error("legacy line passed on while routed to messages");
   leg_follow_a: assert property (age == 2'h3 |-> legacy_irq_n_out == 4'hf || legacy_irq_n_out == $past(legacy_irq_n_in, 3))
      else $error("legacy line not passed on");
   drive_low_a: assert property ((gpio_out & ~gpio_oe) == 4'h0)
      else $error("pin level high without drive");
   irq_cause_a: assert property ($rose(irq) |-> $past(msg_trigger) != 8'h0 || $past(reg_wr))
      else $error("interrupt without event");
endmodule : gpm_port_checker

bind gpm_port gpm_port_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
   .legacy_irq_n_in(legacy_irq_n_in), .legacy_irq_n_out(legacy_irq_n_out), .msg_trigger(msg_trigger), .irq(irq));

// ### gpm_board.sv
/* Board model for the four general-purpose pins and the legacy interrupt lines.
   Assumes the bench picks which lines the board pulls low; every line has a pull-up. */
`timescale 1ns/1ns
module gpm_board (
   input wire logic [gpm_pkg::PIN_N-1:0] gpio_out, // Device pin level
   input wire logic [gpm_pkg::PIN_N-1:0] gpio_oe, // Device drives pin
   input wire logic [gpm_pkg::PIN_N-1:0] pin_pull, // Board pulls pin low
   input wire logic [gpm_pkg::LEG_N-1:0] leg_pull, // Board asserts legacy line
   output logic [gpm_pkg::PIN_N-1:0] gpio_in, // Wire level seen by device
   output logic [gpm_pkg::LEG_N-1:0] legacy_irq_n_in // Legacy lines, low active
);
   // Pull-up wins only when nobody drives, so a released open-drain pin reads high
   always_comb begin
      for (int i = 0; i < gpm_pkg::PIN_N; i++) begin
         gpio_in[i] = gpio_oe[i] ? gpio_out[i] : !pin_pull[i];
      end
   end
   assign legacy_irq_n_in = ~leg_pull;
endmodule : gpm_board

// ### testbench.sv
/* Self-checking bench for gpm_port with a board model on the pins.
   Assumes the checker is bound to gpm_port from its own file. */
`timescale 1ns/1ns
module testbench;
   logic ref_clk = 1'b0;
   logic nrst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0] gpio_in, gpio_out, gpio_oe, legacy_irq_n_in, legacy_irq_n_out, v, p;
   logic [3:0] pin_pull = 4'h0;
   logic [3:0] leg_pull = 4'h0;
   logic [7:0] msg_trigger;
   logic irq;
   logic rd_seen = 1'b0;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] rd_q[$];
   logic [7:0] trig_q[$];

   always #2 ref_clk = ~ref_clk;

   gpm_port dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .legacy_irq_n_in(legacy_irq_n_in), .legacy_irq_n_out(legacy_irq_n_out), .msg_trigger(msg_trigger), .irq(irq));
   gpm_board u_board (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_pull(pin_pull), .leg_pull(leg_pull),
      .gpio_in(gpio_in), .legacy_irq_n_in(legacy_irq_n_in));

   task automatic chk_rd(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_rd

   task automatic chk_sig(input string what, input logic [7:0] exp, input logic [7:0] got);
      chk_rd(what, {24'h0, exp}, {24'h0, got});
   endtask : chk_sig

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // Strobes are held between calls, so back-to-back accesses never assign a signal twice in a step
   task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, 1'b1, a, 32'h0);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 12'h000, 32'h0);
   endtask : idle

   // Read data stand only in the cycle after the strobe; triggers are taken in order
   always @(posedge ref_clk) begin
      cycles++;
      if (rd_seen) chk_rd("read data", rd_q.pop_front(), reg_rdata);
      if (msg_trigger !== 8'h0) chk_sig("trigger", trig_q.pop_front(), msg_trigger);
      rd_seen <= reg_rd;
      if (cycles == 3000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(28685));
      // A real falling edge, so the asynchronous reset acts before the first clock edge
      nrst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(gpm_pkg::OFF_PIN_MODE_CONTROL, 32'h0);
      rd(gpm_pkg::OFF_PIN_OUTPUT_VALUE, 32'h0);
      chk_sig("legacy after reset", 8'h0f, {4'h0, legacy_irq_n_out});
      rd(gpm_pkg::OFF_LEGACY_IRQ_ROUTING, 32'h0);
      rd(gpm_pkg::OFF_PIN_LEVEL_READBACK, 32'hf);
      wr(gpm_pkg::OFF_PIN_LEVEL_READBACK, 32'h0);
      rd(gpm_pkg::OFF_PIN_LEVEL_READBACK, 32'hf);
      rd(12'h300, 32'h0);
      v = 4'($urandom());
      wr(gpm_pkg::OFF_PIN_MODE_CONTROL, {24'($urandom()), v, v});
      rd(gpm_pkg::OFF_PIN_MODE_CONTROL, {24'h0, v, v});
      $display("test registers done");
      for (int m = 0; m < 3; m++) begin
         v = 4'($urandom());
         p = (m == 1) ? 4'h0 : 4'($urandom());
         wr(gpm_pkg::OFF_PIN_MODE_CONTROL, {24'h0, {4{2'(m)}}});
         pin_pull <= p;
         wr(gpm_pkg::OFF_PIN_OUTPUT_VALUE, {28'($urandom()), v});
         rd(gpm_pkg::OFF_PIN_OUTPUT_VALUE, {28'h0, v});
         idle(2);
         #1;
         chk_sig("drive enable", {4'h0, (m == 1) ? 4'hf : (m == 2) ? ~v : 4'h0}, {4'h0, gpio_oe});
         chk_sig("pin out", {4'h0, (m == 1) ? v : 4'h0}, {4'h0, gpio_out});
         idle(4);
         rd(gpm_pkg::OFF_PIN_LEVEL_READBACK, {28'h0, (m == 1) ? v : (m == 2) ? (v & ~p) : ~p});
      end
      $display("test pin drive done");
      pin_pull <= 4'h0;
      wr(gpm_pkg::OFF_EVENT_MASK, 32'hff);
      wr(gpm_pkg::OFF_PIN_MODE_CONTROL, 32'h3f);
      idle(3);
      #1;
      chk_sig("drive enable", 8'h0, {4'h0, gpio_oe});
      for (int n = 0; n < 4; n++) begin
         if (n < 3) trig_q.push_back(8'h1 << n);
         pin_pull[n] <= 1'b1;
         idle(6);
         pin_pull[n] <= 1'b0;
         idle(4);
      end
      #1;
      chk_sig("interrupt", 8'h1, {7'h0, irq});
      rd(gpm_pkg::OFF_EVENT_STATUS, 32'h7);
      wr(gpm_pkg::OFF_EVENT_MASK, 32'h0);
      #1;
      chk_sig("interrupt masked", 8'h0, {7'h0, irq});
      wr(gpm_pkg::OFF_EVENT_STATUS, 32'h7);
      rd(gpm_pkg::OFF_EVENT_STATUS, 32'h0);
      $display("test pin interrupts done");
      wr(gpm_pkg::OFF_LEGACY_IRQ_ROUTING, 32'hfffffffe);
      rd(gpm_pkg::OFF_LEGACY_IRQ_ROUTING, 32'h0);
      v = 4'($urandom());
      leg_pull <= v;
      idle(4);
      #1;
      chk_sig("legacy onward", {4'h0, ~v}, {4'h0, legacy_irq_n_out});
      leg_pull <= 4'h0;
      idle(3);
      wr(gpm_pkg::OFF_LEGACY_IRQ_ROUTING, 32'h1);
      rd(gpm_pkg::OFF_LEGACY_IRQ_ROUTING, 32'h1);
      for (int k = 0; k < 4; k++) begin
         trig_q.push_back(8'h10 << k);
         leg_pull[k] <= 1'b1;
         idle(6);
         #1;
         chk_sig("legacy held", 8'h0f, {4'h0, legacy_irq_n_out});
         leg_pull[k] <= 1'b0;
         idle(4);
      end
      $display("test legacy routing done");
      idle(3);
      chk_rd("pending triggers", 32'h0, 32'(trig_q.size()));
      chk_rd("pending reads", 32'h0, 32'(rd_q.size()));
      wrap_up();
   end
endmodule : testbench
